// [rspm_top.v]
// Reset source ranking, reset cause status, boot strap capture and
// power mode sequencing. Assumes a byte register port and that the
// supply monitor drives por_req; retained status survives sys resets.
// How it works
// RULE1: Power-on/brown-out is top reset, resets everything; por_req keeps lockup, filter, protect and slow divide
// RULE2: Wake reset next; separate sleep/stop flags
// RULE3: Leaving sleep always goes through reset
// RULE4: Active-low reset pin ranks below wake
// RULE5: Pin reset in power-save becomes wake reset
// RULE6: Pin filtered by programmable blanking time register
// RULE7: External watchdog overflow/closed-window service resets
// RULE8: Internal watchdog, software share lowest rank
// RULE9: Hard resets switch system clock to PLL; the code does so only when strap_tms is low, otherwise clk_to_pll is cleared
// RULE10: Lockup enable bit7, flag bit0, rest zero
// RULE11: Protection blocks lockup bit writes
// RULE12: Core lockup acts like software reset
// RULE13: Status kept across resets; POR sets only flag
// RULE14: Status flags one-hot per reset cause
// RULE15: Several flags may coexist; highest ranked wins
// RULE16: Hard resets sample three boot strap pins
// RULE17: Strap 0 user mode; 1,1,0 debug
// RULE18: Four modes; sleep left only by reset
// RULE19: Slow mode divides clock by programmable factor
// RULE20: Stop gates clock; only wake/pin restart
// RULE21: Sleep wake generates reset to defaults
// RULE22: Pending requests granted sleep, stop, slow
// RULE23: Boot not relatched on soft/internal watchdog
// RULE24: Reset release synchronised to system clock
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`include "rspm_regs.vh"
module rspm_top (
  input  wire       clk,
  input  wire       rst,
  input  wire       por_req,
  input  wire       reset_pin_n,
  input  wire       wake_event,
  input  wire       ext_wdt_overflow,
  input  wire       ext_wdt_closed_service,
  input  wire       int_wdt_req,
  input  wire       soft_req,
  input  wire       core_lockup,
  input  wire       strap_tms,
  input  wire       strap_port_a,
  input  wire       strap_port_b,
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_en,
  input  wire       rd_en,
  output reg  [7:0] rdata,
  output reg        sys_reset,
  output reg        clk_to_pll,
  output reg  [1:0] power_mode,
  output wire       core_clk_en,
  output reg  [1:0] boot_mode
);
  // Reset cause indices for ranking
  // Lower index means higher rank; the preemption compare relies on it
  localparam SRC_NONE = 3'h0;
  localparam SRC_POR  = 3'h1;
  localparam SRC_WAKE = 3'h2;
  localparam SRC_PIN  = 3'h3;
  localparam SRC_EWDT = 3'h4;
  localparam SRC_SOFT = 3'h5;

  reg  [7:0] lockup_ctrl_r;        // Lockup enable and flag
  reg  [7:0] status_a_r;           // Retained reset cause flags
  reg  [7:0] status_b_r;           // Copy of previous cause set
  reg  [7:0] filter_r;             // Pin blanking time in cycles
  reg  [2:0] power_req_r;          // Power-save request bits
  reg        protect_r;            // Protection active
  reg  [7:0] slow_div_r;           // Slow mode divide factor
  reg  [1:0] mode_r;               // Current power mode
  reg  [7:0] pin_cnt_r;            // Pin low duration counter
  reg        pin_hit_r;            // Filtered pin request seen
  reg  [3:0] stretch_r;            // Reset stretch counter
  reg  [2:0] src_r;                // Cause of the reset in progress
  reg  [7:0] div_cnt_r;            // Slow mode clock divider
  reg        por_done_r;           // Powered since last POR
  wire [2:0] req_sync;             // Synchronised async requests
  wire       por_s;
  wire       ewdt_s;
  wire       pin_low_s;
  wire       ewdt_req;
  wire       save_mode;
  wire       lockup_req;
  reg  [2:0] src_nxt;              // Ranked cause this cycle
  reg  [7:0] flags_nxt;            // Flags for that cause
  wire       take_cause;           // Ranked cause starts or preempts
  wire       new_reset;            // Cause arrives with no reset running

  assign ewdt_req = ext_wdt_overflow | ext_wdt_closed_service;  // RULE7

  // No reset on the synchroniser: a request already asserted at
  // reset release must still be seen afterwards.
  // Async requests cross into the clock domain before use
  rspm_sync #(
    .W (3)
  ) u_sync (
    .clk (clk),
    .rst (1'b0),
    .d   ({por_req, ewdt_req, ~reset_pin_n}),
    .q   (req_sync)
  );  // RULE24
  assign por_s     = req_sync[2];
  assign ewdt_s    = req_sync[1];
  assign pin_low_s = req_sync[0];  // RULE4

  // Stop and sleep together form power-save for the ranking logic
  assign save_mode  = (mode_r == `RSPM_MODE_STOP) || (mode_r == `RSPM_MODE_SLEEP);
  assign lockup_req = core_lockup & lockup_ctrl_r[`RSPM_LOCKUP_EN_BIT];

  // Taken when idle or when it outranks the cause in progress; equal or
  // lower ranks are dropped so a held request cannot stack resets.
  assign take_cause = (src_nxt != SRC_NONE) && (stretch_r == 4'h0 || src_nxt < src_r);
  assign new_reset  = take_cause && (stretch_r == 4'h0);

  // Pin blanking filter: a low shorter than filter_r is ignored
  // Counter saturates at the threshold instead of wrapping, so a long
  // low keeps pin_hit_r set; the request cannot vanish by overflow.
  // A zero threshold passes the pin after a single cycle.
  always @(posedge clk) begin
    if (rst) begin
      pin_cnt_r <= 8'h00;
      pin_hit_r <= 1'b0;
    end else if (!pin_low_s) begin
      pin_cnt_r <= 8'h00;
      pin_hit_r <= 1'b0;
    end else if (pin_cnt_r >= filter_r) begin
      pin_hit_r <= 1'b1;  // RULE6
    end else begin
      pin_cnt_r <= pin_cnt_r + 8'h01;
    end
  end

  // Rank sources; flags follow the one-hot cause encoding
  // Power-save blocks every source but power-on and the wake path.
  // There the pin is folded into the wake path, adding its flag to the
  // stop-wake code; sleep records no pin flag.
  // Lockup counts as a software reset only while its enable is set.
  always @* begin
    src_nxt   = SRC_NONE;
    flags_nxt = 8'h00;
    if (por_s) begin
      src_nxt   = SRC_POR;  // RULE1
      flags_nxt = `RSPM_ST_POR_VALUE;  // RULE13
    end else if ((wake_event || pin_hit_r) && save_mode) begin
      src_nxt = SRC_WAKE;  // RULE2
      if (mode_r == `RSPM_MODE_SLEEP) begin
        flags_nxt[`RSPM_ST_SLEEP_WAKE_BIT] = 1'b1;  // RULE21
      end else begin
        flags_nxt[`RSPM_ST_STOP_WAKE_BIT] = 1'b1;  // RULE14
        flags_nxt[`RSPM_ST_PIN_BIT]       = pin_hit_r;  // RULE5
      end
    end else if (pin_hit_r && !save_mode) begin
      src_nxt   = SRC_PIN;  // RULE4
      flags_nxt[`RSPM_ST_PIN_BIT] = 1'b1;
    end else if (ewdt_s && !save_mode) begin
      src_nxt   = SRC_EWDT;  // RULE7
      flags_nxt[`RSPM_ST_EWDT_BIT] = 1'b1;
    end else if (!save_mode && (int_wdt_req || soft_req || lockup_req)) begin
      src_nxt   = SRC_SOFT;  // RULE8
      flags_nxt[`RSPM_ST_IWDT_BIT] = int_wdt_req;  // RULE15
      flags_nxt[`RSPM_ST_SOFT_BIT] = soft_req | lockup_req;  // RULE12
    end
  end

  // Reset stretch: hold sys_reset for a fixed count, release on clock
  // The counter alone sets the reset length. A preempting cause reloads
  // it, so the output stays high a full stretch after the highest cause.
  // sys_reset drops on the edge where the counter reaches zero, which
  // keeps the two in step for the status and boot logic.
  always @(posedge clk) begin
    if (rst) begin
      stretch_r <= `RSPM_STRETCH_CYCLES;
      src_r     <= SRC_POR;
      sys_reset <= 1'b1;
    end else if (take_cause) begin
      // Higher rank overrides a reset already in progress
      stretch_r <= `RSPM_STRETCH_CYCLES;
      src_r     <= src_nxt;
      sys_reset <= 1'b1;  // RULE3
    end else if (stretch_r != 4'h0) begin
      stretch_r <= stretch_r - 4'h1;
      sys_reset <= (stretch_r != 4'h1);  // RULE24
    end else begin
      sys_reset <= 1'b0;
    end
  end

  // Clock source and boot straps: only hard resets switch or relatch
  // Relatch falls on the last stretch cycle, so straps must be stable
  // by then. Software and internal watchdog resets leave both the boot
  // selection and the clock source as they were.
  always @(posedge clk) begin
    if (rst) begin
      clk_to_pll <= 1'b0;
      boot_mode  <= `RSPM_BOOT_USER;
    end else if (sys_reset && stretch_r == 4'h1 && src_r != SRC_SOFT) begin
      // Follows the strap being latched now, not the old boot mode
      clk_to_pll <= !strap_tms;  // RULE9
      if (!strap_tms) begin
        boot_mode <= `RSPM_BOOT_USER;  // RULE17
      end else if (strap_port_a && !strap_port_b) begin
        boot_mode <= `RSPM_BOOT_DEBUG;  // RULE16
      end else begin
        boot_mode <= `RSPM_BOOT_UNDEF;  // RULE23
      end
    end
  end

  // Power mode sequencer; sleep is left only through the reset path
  // Sleep has no exit branch on purpose: only sys_reset brings it back
  // to active. A wake in stop also raises a wake reset through the
  // ranking logic; the stop exit branch keeps the state machine
  // consistent on that same edge.
  always @(posedge clk) begin
    if (rst || sys_reset) begin
      mode_r <= `RSPM_MODE_ACTIVE;  // RULE21
    end else begin
      case (mode_r)
        `RSPM_MODE_ACTIVE, `RSPM_MODE_SLOW: begin
          if (power_req_r[`RSPM_PC_SLEEP_BIT]) begin
            mode_r <= `RSPM_MODE_SLEEP;  // RULE22
          end else if (power_req_r[`RSPM_PC_STOP_BIT]) begin
            mode_r <= `RSPM_MODE_STOP;
          end else if (power_req_r[`RSPM_PC_SLOW_BIT]) begin
            mode_r <= `RSPM_MODE_SLOW;
          end else begin
            mode_r <= `RSPM_MODE_ACTIVE;
          end
        end
        `RSPM_MODE_STOP: begin
          // Interrupts and watchdog ignored; only wake or pin restarts
          if (wake_event) begin
            mode_r <= `RSPM_MODE_ACTIVE;  // RULE20
          end
        end
        `RSPM_MODE_SLEEP: begin
          mode_r <= `RSPM_MODE_SLEEP;  // RULE18
        end
        default: begin
          mode_r <= `RSPM_MODE_ACTIVE;
        end
      endcase
    end
  end

  // Divider: one-cycle clock enable, every slow_div_r + 1 cycles in slow mode
  // Restarts whenever slow mode is left, so entering slow mode begins
  // with an enable pulse. A factor of zero gives an enable every cycle,
  // the same as active mode.
  always @(posedge clk) begin
    if (rst || mode_r != `RSPM_MODE_SLOW || div_cnt_r >= slow_div_r) begin
      div_cnt_r <= 8'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;  // RULE19
    end
  end
  assign core_clk_en = (mode_r == `RSPM_MODE_ACTIVE) ||
                       (mode_r == `RSPM_MODE_SLOW && div_cnt_r == 8'h00);  // RULE20

  // Mode output mirrors the state register directly
  always @* begin
    power_mode = mode_r;
  end

  // Registers; status is retained over every reset but power-on
  // Order of precedence: power-on beats any other cause, a recorded
  // cause beats a software clear of the same register, and hardware
  // setting the lockup flag beats a write. Power requests are dropped
  // by every system reset so the block always restarts active.
  // Status b takes the previous set once per reset, not per preemption.
  always @(posedge clk) begin
    if (rst) begin
      lockup_ctrl_r <= 8'h00;
      status_a_r    <= 8'h00;
      status_b_r    <= 8'h00;
      filter_r      <= `RSPM_FILTER_RESET;
      power_req_r   <= 3'h0;
      protect_r     <= 1'b1;
      slow_div_r    <= `RSPM_SLOW_DIV_RESET;
      por_done_r    <= 1'b0;
    end else begin
      if (src_nxt == SRC_POR) begin
        status_a_r <= `RSPM_ST_POR_VALUE;  // RULE13
        status_b_r <= 8'h00;
        por_done_r <= 1'b1;
      end else if (take_cause) begin
        status_a_r <= status_a_r | flags_nxt;  // RULE15
        if (new_reset) begin
          status_b_r <= status_a_r;
        end
      end else if (wr_en && addr == `RSPM_ADDR_STATUS_A) begin
        status_a_r <= status_a_r & ~wdata;  // Write one to clear
      end
      if (sys_reset) begin
        power_req_r <= 3'h0;  // Power requests cleared by any reset
      end else if (wr_en && addr == `RSPM_ADDR_POWER_CTRL) begin
        power_req_r <= wdata[2:0];
      end
      if (lockup_req) begin
        lockup_ctrl_r[`RSPM_LOCKUP_FLAG_BIT] <= 1'b1;  // Set beats clear
      end else if (wr_en && addr == `RSPM_ADDR_LOCKUP_CTRL && !protect_r) begin
        lockup_ctrl_r[`RSPM_LOCKUP_FLAG_BIT] <= wdata[`RSPM_LOCKUP_FLAG_BIT];  // RULE11
      end
      if (wr_en && addr == `RSPM_ADDR_LOCKUP_CTRL && !protect_r) begin
        lockup_ctrl_r[`RSPM_LOCKUP_EN_BIT] <= wdata[`RSPM_LOCKUP_EN_BIT];  // RULE10
      end
      if (wr_en && addr == `RSPM_ADDR_PIN_FILTER) begin
        filter_r <= wdata;  // RULE6
      end
      if (wr_en && addr == `RSPM_ADDR_SLOW_DIV) begin
        slow_div_r <= wdata;
      end
      if (wr_en && addr == `RSPM_ADDR_PROTECT) begin
        protect_r <= (wdata != `RSPM_PROTECT_KEY);
      end
    end
  end

  // Read data one cycle after the read strobe, zero elsewhere
  // Registered output; unused upper bits read zero. The lockup register
  // is masked so its reserved bits never show internal state.
  always @(posedge clk) begin
    if (rst || !rd_en) begin
      rdata <= 8'h00;
    end else begin
      case (addr)
        `RSPM_ADDR_LOCKUP_CTRL: rdata <= lockup_ctrl_r & 8'h81;  // RULE10
        `RSPM_ADDR_STATUS_A:    rdata <= status_a_r;
        `RSPM_ADDR_STATUS_B:    rdata <= status_b_r;
        `RSPM_ADDR_PIN_FILTER:  rdata <= filter_r;
        `RSPM_ADDR_POWER_CTRL:  rdata <= {3'h0, mode_r, power_req_r};
        `RSPM_ADDR_PROTECT:     rdata <= {7'h00, protect_r};
        `RSPM_ADDR_SLOW_DIV:    rdata <= slow_div_r;
        `RSPM_ADDR_BOOT_MODE:   rdata <= {5'h00, por_done_r, boot_mode};
        default:                rdata <= 8'h00;
      endcase
    end
  end
endmodule // rspm_top

// [rspm_regs.vh]
// Register offsets, field positions, reset values and timing counts
// for the reset source and power mode supervisor.
// Assumes a simple strobe-based register port with byte-wide registers.
`ifndef RSPM_REGS_VH
`define RSPM_REGS_VH

// Register offsets (byte-wide registers, word index = offset)
`define RSPM_ADDR_LOCKUP_CTRL   4'h0
`define RSPM_ADDR_STATUS_A      4'h1
`define RSPM_ADDR_STATUS_B      4'h2
`define RSPM_ADDR_PIN_FILTER    4'h3
`define RSPM_ADDR_POWER_CTRL    4'h4
`define RSPM_ADDR_PROTECT       4'h5
`define RSPM_ADDR_SLOW_DIV      4'h6
`define RSPM_ADDR_BOOT_MODE     4'h7
`define RSPM_ADDR_WIDTH         4

// Lockup control fields
`define RSPM_LOCKUP_EN_BIT      7
`define RSPM_LOCKUP_FLAG_BIT    0

// Reset cause flag positions (status byte)
`define RSPM_ST_STOP_WAKE_BIT   1
`define RSPM_ST_SLEEP_WAKE_BIT  2
`define RSPM_ST_SOFT_BIT        3
`define RSPM_ST_IWDT_BIT        4
`define RSPM_ST_EWDT_BIT        5
`define RSPM_ST_PIN_BIT         6
`define RSPM_ST_POR_BIT         7

// Status value on a power-on reset
`define RSPM_ST_POR_VALUE       8'h80

// Power control fields
`define RSPM_PC_SLEEP_BIT       0
`define RSPM_PC_STOP_BIT        1
`define RSPM_PC_SLOW_BIT        2

// Power mode codes
`define RSPM_MODE_ACTIVE        2'h0
`define RSPM_MODE_SLOW          2'h1
`define RSPM_MODE_STOP          2'h2
`define RSPM_MODE_SLEEP         2'h3

// Boot mode codes
`define RSPM_BOOT_USER          2'h0
`define RSPM_BOOT_DEBUG         2'h1
`define RSPM_BOOT_UNDEF         2'h2

// Protection unlock key, reset values
`define RSPM_PROTECT_KEY        8'hA5
`define RSPM_FILTER_RESET       8'h04
`define RSPM_SLOW_DIV_RESET     8'h01

// Reset stretch length in system clock cycles
`define RSPM_STRETCH_CYCLES     4'h8

`endif

// [rspm_sync.v]
// Two-flop synchroniser for asynchronous reset request levels.
// Assumes one system clock; the first flop feeds only the second.
`timescale 1ns/100ps
module rspm_sync #(
  parameter W = 1                  // Number of bits
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_r;              // First stage, read only by second
  reg [W-1:0] sync_r;              // Second stage

  // Two-stage capture to settle metastability
  always @(posedge clk) begin
    if (rst) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;
endmodule // rspm_sync

// [rspm_checker.sv]
// Checker on rspm_top ports: reset stretch, gating, boot retention.
// Assumes one clock clk and a synchronous active-high rst.
`timescale 1ns/100ps
module rspm_checker (
  input logic       clk,
  input logic       rst,
  input logic       soft_req,
  input logic       rd_en,
  input logic [3:0] addr,
  input logic [7:0] rdata,
  input logic       sys_reset,
  input logic       clk_to_pll,
  input logic [1:0] power_mode,
  input logic       core_clk_en,
  input logic [1:0] boot_mode
);
  // Single domain, so one clock and one disable
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Supply reset release keeps the system reset for the full stretch
  a_rst_stretch: assert property ($fell(rst) |-> sys_reset [*8])
    else $error("short reset after supply reset");
  // Software request acts at once outside stop and sleep
  a_soft_go: assert property (soft_req && !sys_reset && !power_mode[1] |=> sys_reset)
    else $error("software request ignored");
  a_resv_zero: assert property (
    $past(rd_en) && $past(addr) == 4'h0 |-> rdata[6:1] == 6'h00)
    else $error("reserved lockup bits nonzero");
  a_stop_gate: assert property (power_mode[1] |-> !core_clk_en)
    else $error("core clock runs in stop or sleep");
  a_active_clk: assert property (power_mode == 2'h0 && !sys_reset |-> core_clk_en)
    else $error("core clock gated in active mode");
  // Leaving sleep is only ever a side effect of a reset
  a_sleep_exit: assert property (
    $past(power_mode) == 2'h3 && power_mode != 2'h3 |-> sys_reset || $past(sys_reset))
    else $error("sleep left without reset");
  a_boot_hold: assert property (
    $changed(boot_mode) |-> $past(sys_reset) || $past(sys_reset, 2))
    else $error("boot mode changed outside reset");
  a_pll_hold: assert property (
    $changed(clk_to_pll) |-> $past(sys_reset) || $past(sys_reset, 2))
    else $error("clock source changed outside reset");
  // Main scenarios reached
  c_reset: cover property ($rose(sys_reset));
  c_sleep: cover property (power_mode == 2'h3);
  c_slow: cover property (power_mode == 2'h1 && core_clk_en);
endmodule // rspm_checker

bind rspm_top rspm_checker u_chk (.clk(clk), .rst(rst), .soft_req(soft_req),
  .rd_en(rd_en), .addr(addr), .rdata(rdata), .sys_reset(sys_reset),
  .clk_to_pll(clk_to_pll), .power_mode(power_mode), .core_clk_en(core_clk_en),
  .boot_mode(boot_mode));

// [rspm_partner.sv]
// Far-side model: reset pin with pull-up, wake pin, boot straps.
// Assumes calls from the bench right after rising edges.
`timescale 1ns/100ps
module rspm_partner (
  input  logic clk,
  output logic reset_pin_n,
  output logic wake_event,
  output logic strap_tms,
  output logic strap_port_a,
  output logic strap_port_b
);
  // Pin rests high on its pull-up, wake rests low
  initial begin
    {reset_pin_n, wake_event} = 2'h2;
    {strap_tms, strap_port_a, strap_port_b} = 3'h0;
  end
  // Active-low pin held k edges, then let go
  task pin_low(input int k);
    @(posedge clk);
    reset_pin_n <= 1'b0;
    repeat (k) @(posedge clk);
    reset_pin_n <= 1'b1;
  endtask
  // One-cycle enabled wake event
  task wake();
    @(posedge clk);
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
  endtask
  // Straps are static pins, changed only between resets
  task straps(input logic [2:0] v);
    @(posedge clk);
    {strap_tms, strap_port_a, strap_port_b} <= v;
  endtask
endmodule // rspm_partner

// [rspm_top_tb_top.sv]
// Self-checking bench for rspm_top with a model of status and boot.
// Assumes the partner drives pin, wake and straps.
`timescale 1ns/100ps
module rspm_top_tb_top;
  logic        clk, rst, wr_en, rd_en, sys_reset, clk_to_pll, core_clk_en;
  logic        reset_pin_n, wake_event, strap_tms, strap_port_a, strap_port_b;
  logic [5:0]  rq;                      // Por, lockup, watchdogs, soft
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [1:0]  power_mode, boot_mode, boot_e;
  logic        pll_e, s;
  logic [31:0] seed;
  int          miscompares, checks, st_a, st_b, n;
  int          fl[4] = '{8, 16, 32, 32}; // Flag per source

  rspm_top DUT (.clk(clk), .rst(rst), .por_req(rq[5]), .reset_pin_n(reset_pin_n),
    .wake_event(wake_event), .ext_wdt_overflow(rq[2]), .ext_wdt_closed_service(rq[3]),
    .int_wdt_req(rq[1]), .soft_req(rq[0]), .core_lockup(rq[4]), .strap_tms(strap_tms),
    .strap_port_a(strap_port_a), .strap_port_b(strap_port_b), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sys_reset(sys_reset),
    .clk_to_pll(clk_to_pll), .power_mode(power_mode), .core_clk_en(core_clk_en),
    .boot_mode(boot_mode));
  rspm_partner P (.clk(clk), .reset_pin_n(reset_pin_n), .wake_event(wake_event),
    .strap_tms(strap_tms), .strap_port_a(strap_port_a), .strap_port_b(strap_port_b));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Fixed-seed xorshift for strap patterns
  function logic [2:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[2:0];
  endfunction
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Bus cycles; read data sampled in the cycle after the strobe
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Requests held two edges, long enough for the synchronisers
  task req(input logic [5:0] m);
    @(posedge clk);
    rq <= m;
    repeat (2) @(posedge clk);
    rq <= 6'h00;
  endtask
  // Window of w edges; x says whether one whole reset is due
  task watch(input int w, input logic x);
    s = 1'b0;
    repeat (w) begin
      @(posedge clk);
      #1 s |= sys_reset;
    end
    chk({6'h00, s, sys_reset}, {6'h00, x, 1'b0});
  endtask
  // Expected reset: model update, then status, boot and clock compare
  task got(input logic [7:0] f);
    watch(40, 1'b1);
    st_b = (f == 8'h80) ? 0 : st_a;
    st_a = (f == 8'h80) ? f : (st_a | f);
    if (f != 8'h08 && f != 8'h10) begin
      boot_e = !strap_tms ? 2'h0 : ({strap_port_a, strap_port_b} == 2'h2 ? 2'h1 : 2'h2);
      pll_e = boot_e == 2'h0;
    end
    chk({6'h00, boot_mode}, {6'h00, boot_e});
    chk({7'h00, clk_to_pll}, {7'h00, pll_e});
    rd(4'h1, st_a[7:0]);
    rd(4'h2, st_b[7:0]);
  endtask
  task md(input logic [1:0] e);
    repeat (3) @(posedge clk);
    #1 chk({6'h00, power_mode}, {6'h00, e});
  endtask
  // Core clock enables over 20 settled cycles
  task cnt(input int e);
    n = 0;
    repeat (8) @(posedge clk);
    repeat (20) begin
      @(posedge clk);
      #1 n += core_clk_en;
    end
    chk(n[7:0], e[7:0]);
  endtask
  task conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst, rq, wr_en, rd_en, addr, wdata} = {1'b1, 20'h00000};
    {seed, boot_e, pll_e} = {32'h00000057, 3'h1};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (12) @(posedge clk);
    rd(4'h0, 8'h00);
    rd(4'h3, 8'h04);
    rd(4'hF, 8'h00);
    wr(4'h1, 8'hFF);
    for (int k = 0; k < 4; k++) begin
      P.straps(xs());
      req(6'h01 << k);
      got(fl[k][7:0]);
    end
    wr(4'h1, 8'hFF);
    st_a = 0;
    req(6'h05);
    got(8'h28);
    P.pin_low(3);
    watch(24, 1'b0);
    wr(4'h3, 8'h0A);
    rd(4'h3, 8'h0A);
    P.pin_low(9);
    watch(24, 1'b0);
    // Pin let go before the stretch ends, so one reset is recorded
    P.pin_low(12);
    got(8'h40);
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'h00);
    wr(4'h5, 8'hA5);
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'h81);
    req(6'h10);
    got(8'h08);
    wr(4'h4, 8'h07);
    md(2'h3);
    req(6'h01);
    watch(24, 1'b0);
    P.wake();
    got(8'h04);
    md(2'h0);
    wr(4'h4, 8'h06);
    md(2'h2);
    req(6'h02);
    watch(24, 1'b0);
    P.pin_low(12);
    got(8'h42);
    wr(4'h1, 8'hFF);
    st_a = 0;
    wr(4'h4, 8'h02);
    md(2'h2);
    P.wake();
    got(8'h02);
    md(2'h0);
    wr(4'h4, 8'h04);
    md(2'h1);
    cnt(10);
    wr(4'h6, 8'h03);
    cnt(5);
    req(6'h20);
    got(8'h80);
    conclude();
  end
  // Hang guard well past the expected run length
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    conclude();
  end
endmodule // rspm_top_tb_top
